//--- bmc_top.sv
/*
 * Buck output mode control: selects the active voltage setting, the
 * PWM/PFM mode, sequences thermal shutdown and re-arm, blocks switching
 * under undervoltage and drives the output discharge, behind an APB slave.
 * Assumes analog sense inputs already synchronous to clock.
 */
// Notes on behaviour
// R1: With the gate bit set and the select pin low, setting 0's code is the output target.
// R2: In every other gate and pin combination, setting 1's code is the output target.
// R3: Codes span 0.6 V to 1.39375 V in 6.25 mV steps; seven bits never exceed the range, so no code is clamped.
// R4: Target is 0.6 V plus code times 6.25 mV, code zero being the minimum.
// R5: After reset the pin-high setting holds 1.15 V and the pin-low setting 1.025 V.
// R6: Each setting has a forced-PWM bit that keeps the stage in PWM while active.
// R7: Without forced PWM the mode follows the load-demand indication.
// R8: In PWM the main switch turns on at the start of every fixed-rate cycle.
// R9: Over-temperature enters thermal shutdown with both switches off.
// R10: With re-arm clear, shutdown holds until the enable pin is toggled.
// R11: With re-arm set, the block restarts on temperature recovery keeping registers.
// R12: Undervoltage lockout keeps both switches off.
// R13: The discharge enable bit drives the grounding path and resets disabled.
// R14: A gate bit of 0 masks the pin so the pin-high setting applies.
// R15: A rising enable edge starts power-up and a low enable turns the stage off.
`default_nettype none
module bmc_top #(
  parameter int unsigned SW_DIV_P = bmc_pkg::SW_DIV
) (
  input  wire logic              clock,              // system clock
  input  wire logic              rst,                // synchronous reset
  input  wire logic              psel,               // apb select
  input  wire logic              penable,            // apb access phase
  input  wire logic              pwrite,             // apb write
  input  wire logic [11:0]       paddr,              // apb byte address
  input  wire logic [31:0]       pwdata,             // apb write data
  output logic      [31:0]       prdata,             // apb read data
  output logic                   pready,             // apb ready
  output logic                   pslverr,            // apb error
  input  wire logic              enable_pin,         // converter enable
  input  wire logic              voltage_select_pin, // setting select
  input  wire bmc_pkg::bmc_sense_t sense,            // analog detectors
  output bmc_pkg::bmc_drive_t    drive,              // power stage controls
  output logic                   irq                 // level interrupt
);
  import bmc_pkg::*;

  initial begin
    if (SW_DIV_P < 2 || SW_DIV_P > 255) $error("bmc_top: SW_DIV_P out of range");
  end

  typedef struct packed {
    logic [6:0]       vout_code_set0;
    logic [6:0]       vout_code_set1;
    logic             force_pwm_set0;
    logic             force_pwm_set1;
    logic             select_pin_gate;
    logic             thermal_auto_restart;
    logic             output_discharge_en;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    bmc_state_t       state;
    logic             en_prev;
    logic             uv_prev;
    logic             pwm_mode;
    logic             main_on;
    logic             sync_on;
    logic [6:0]       code_out;
    logic [31:0]      rdata;
    logic             slverr;
  } bmc_regs_t;

  bmc_regs_t cur;
  bmc_regs_t next_cur;
  logic      cycle_start;

  // clamp a setting code to the top of the voltage range; a range of 128 or
  // more codes needs no clamp, and the limit must not wrap in seven bits
  function automatic logic [6:0] clamp_code(input logic [6:0] c);
    clamp_code = (CODE_MAX < 127 && int'(c) > CODE_MAX) ? 7'(CODE_MAX) : c;
  endfunction

  logic       use_set0;
  logic [6:0] active_code;
  logic       active_fpwm;
  logic       access;
  logic       wr;
  logic       en_rise;

  assign use_set0    = cur.select_pin_gate && !voltage_select_pin; // R1 R2 R14
  assign active_code = clamp_code(use_set0 ? cur.vout_code_set0
                                           : cur.vout_code_set1); // R3 R4
  assign active_fpwm = use_set0 ? cur.force_pwm_set0 : cur.force_pwm_set1;
  assign access      = psel && penable;
  assign wr          = access && pwrite;
  assign en_rise     = enable_pin && !cur.en_prev; // R15

  bmc_sw_timer #(
    .DIV         (SW_DIV_P)
  ) u_timer (
    .clock       (clock),
    .rst         (rst),
    .run         (cur.state == BMC_RUN && !sense.uvlo),
    .cycle_start (cycle_start)
  );

  always_comb begin
    logic [IRQ_W-1:0] ev;
    ev       = '0;
    next_cur = cur;
    next_cur.en_prev = enable_pin;
    next_cur.uv_prev = sense.uvlo;
    next_cur.slverr  = 1'b0;

    case (cur.state)
      BMC_OFF: begin
        if (en_rise && !sense.over_temp) begin
          next_cur.state = BMC_RUN; // R15
        end
      end
      BMC_RUN: begin
        if (!enable_pin) begin
          next_cur.state = BMC_OFF; // R15
        end else if (sense.over_temp) begin
          next_cur.state = BMC_TSD; // R9
          ev[IRQ_TSD]    = 1'b1;
        end
      end
      BMC_TSD: begin
        if (!enable_pin) begin
          next_cur.state = BMC_OFF; // R10
        end else if (cur.thermal_auto_restart && sense.temp_recovered
                     && !sense.over_temp) begin
          next_cur.state  = BMC_RUN; // R11
          ev[IRQ_REST]    = 1'b1;
        end
      end
      default: begin
        next_cur.state = BMC_OFF;
      end
    endcase

    if (sense.uvlo && !cur.uv_prev) begin
      ev[IRQ_UVLO] = 1'b1;
    end

    // mode: forced pwm or follow load demand
    next_cur.pwm_mode = active_fpwm ? 1'b1 : sense.load_high; // R6 R7

    // switch drive: main on at each cycle start, sync on for the rest
    if (cur.state != BMC_RUN || sense.uvlo || sense.over_temp) begin
      next_cur.main_on = 1'b0; // R9 R12
      next_cur.sync_on = 1'b0; // R9 R12
    end else if (cycle_start) begin
      next_cur.main_on = 1'b1; // R8
      next_cur.sync_on = 1'b0;
    end else if (cur.main_on) begin
      next_cur.main_on = 1'b0;
      next_cur.sync_on = 1'b1;
    end
    next_cur.code_out = active_code;

    next_cur.rdata = 32'h0000_0000;
    // decoded from the setup phase on, so read data stands at the access edge
    if (psel && !pwrite) begin
      case (paddr)
        OFS_SET0: next_cur.rdata[POS_CODE +: 7] = cur.vout_code_set0;
        OFS_SET1: next_cur.rdata[POS_CODE +: 7] = cur.vout_code_set1;
        OFS_CMD: begin
          next_cur.rdata[POS_FPWM0] = cur.force_pwm_set0;
          next_cur.rdata[POS_FPWM1] = cur.force_pwm_set1;
          next_cur.rdata[POS_GATE]  = cur.select_pin_gate;
        end
        OFS_LIM:  next_cur.rdata[POS_THERMAL_AUTO_RESTART]  = cur.thermal_auto_restart;
        OFS_GOOD: next_cur.rdata[POS_OUTPUT_DISCHARGE_EN] = cur.output_discharge_en;
        OFS_STAT: begin
          next_cur.rdata[1:0] = cur.state;
          next_cur.rdata[2]   = cur.pwm_mode;
          next_cur.rdata[3]   = use_set0;
          next_cur.rdata[10:4] = active_code;
        end
        OFS_IRQ:  next_cur.rdata[IRQ_W-1:0] = cur.irq_status;
        OFS_MASK: next_cur.rdata[IRQ_W-1:0] = cur.irq_mask;
        default:  next_cur.slverr = 1'b1;
      endcase
    end

    if (wr) begin
      case (paddr)
        OFS_SET0: next_cur.vout_code_set0 = pwdata[POS_CODE +: 7];
        OFS_SET1: next_cur.vout_code_set1 = pwdata[POS_CODE +: 7];
        OFS_CMD: begin
          next_cur.force_pwm_set0  = pwdata[POS_FPWM0];
          next_cur.force_pwm_set1  = pwdata[POS_FPWM1];
          next_cur.select_pin_gate = pwdata[POS_GATE]; // R14
        end
        OFS_LIM:  next_cur.thermal_auto_restart = pwdata[POS_THERMAL_AUTO_RESTART];
        OFS_GOOD: next_cur.output_discharge_en  = pwdata[POS_OUTPUT_DISCHARGE_EN]; // R13
        OFS_STAT: begin
        end
        OFS_IRQ:  next_cur.irq_status = cur.irq_status & ~pwdata[IRQ_W-1:0];
        OFS_MASK: next_cur.irq_mask   = pwdata[IRQ_W-1:0];
        default:  next_cur.slverr = 1'b1;
      endcase
    end
    // set wins over a simultaneous clear
    next_cur.irq_status = next_cur.irq_status | ev;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      cur                      <= '0;
      cur.vout_code_set0       <= RST_CODE0; // R5
      cur.vout_code_set1       <= RST_CODE1; // R5
      cur.force_pwm_set0       <= RST_FPWM;
      cur.force_pwm_set1       <= RST_FPWM;
      cur.select_pin_gate      <= RST_GATE;
      cur.thermal_auto_restart <= RST_THERMAL_AUTO_RESTART;
      cur.output_discharge_en  <= RST_OUTPUT_DISCHARGE_EN; // R13
      cur.state                <= BMC_OFF;
      cur.en_prev              <= 1'b1;
    end else begin
      cur <= next_cur;
    end
  end

  assign prdata  = cur.rdata;
  assign pready  = 1'b1;
  assign pslverr = access && next_cur.slverr;
  assign irq     = |(cur.irq_status & cur.irq_mask);

  always_comb begin
    drive.main_on                = cur.main_on;
    drive.sync_on                = cur.sync_on;
    drive.pwm_mode               = cur.pwm_mode;
    drive.discharge              = cur.output_discharge_en; // R13
    drive.vout_code              = cur.code_out;
    drive.thermal_shutdown_state = (cur.state == BMC_TSD);
  end

endmodule
`default_nettype wire

//--- bmc_pkg.sv
/*
 * Package for the buck output mode control block: register map, field
 * positions, reset values, timing counts and shared types.
 * Assumes a 125 MHz system clock and a 32-bit APB register bus.
 */
`default_nettype none
package bmc_pkg;

  localparam int unsigned CLK_HZ   = 125000000;
  localparam int unsigned FSW_HZ   = 3000000;
  localparam int unsigned SW_DIV   = (CLK_HZ + FSW_HZ / 2) / FSW_HZ;

  localparam int unsigned VMIN_UV  = 600000;
  localparam int unsigned VMAX_UV  = 1400000;
  localparam int unsigned STEP_NV  = 6250000;
  localparam int unsigned CODE_MAX = ((VMAX_UV - VMIN_UV) * 1000) / STEP_NV;

  localparam logic [11:0] OFS_SET0   = 12'h000;
  localparam logic [11:0] OFS_SET1   = 12'h004;
  localparam logic [11:0] OFS_CMD    = 12'h008;
  localparam logic [11:0] OFS_LIM    = 12'h00c;
  localparam logic [11:0] OFS_GOOD   = 12'h010;
  localparam logic [11:0] OFS_STAT   = 12'h014;
  localparam logic [11:0] OFS_IRQ    = 12'h018;
  localparam logic [11:0] OFS_MASK   = 12'h01c;

  localparam int unsigned POS_CODE   = 0;
  localparam int unsigned POS_FPWM0  = 0;
  localparam int unsigned POS_FPWM1  = 1;
  localparam int unsigned POS_GATE   = 2;
  localparam int unsigned POS_THERMAL_AUTO_RESTART  = 0;
  localparam int unsigned POS_OUTPUT_DISCHARGE_EN = 0;

  localparam int unsigned IRQ_TSD    = 0;
  localparam int unsigned IRQ_UVLO   = 1;
  localparam int unsigned IRQ_REST   = 2;
  localparam int unsigned IRQ_W      = 3;

  // 1.025 V and 1.15 V as codes above 0.6 V
  localparam logic [6:0] RST_CODE0  = 7'h44;
  localparam logic [6:0] RST_CODE1  = 7'h58;
  localparam logic       RST_GATE   = 1'b1;
  localparam logic       RST_FPWM   = 1'b0;
  localparam logic       RST_THERMAL_AUTO_RESTART  = 1'b0;
  localparam logic       RST_OUTPUT_DISCHARGE_EN = 1'b0;

  typedef enum logic [1:0] {
    BMC_OFF,
    BMC_RUN,
    BMC_TSD
  } bmc_state_t;

  typedef struct packed {
    logic       over_temp;
    logic       temp_recovered;
    logic       uvlo;
    logic       load_high;
  } bmc_sense_t;

  typedef struct packed {
    logic       main_on;
    logic       sync_on;
    logic       pwm_mode;
    logic       discharge;
    logic [6:0] vout_code;
    logic       thermal_shutdown_state;
  } bmc_drive_t;

endpackage
`default_nettype wire

//--- bmc_sw_timer.sv
/*
 * Switching cycle timer: a divider that yields a one-cycle pulse at the
 * start of each switching period.
 * Assumes one clock and a synchronous active-high reset.
 */
`default_nettype none
module bmc_sw_timer #(
  parameter int unsigned DIV = bmc_pkg::SW_DIV
) (
  input  wire logic clock,        // system clock
  input  wire logic rst,          // synchronous reset
  input  wire logic run,          // timer counts while high
  output logic      cycle_start   // pulse at the start of a period
);
  import bmc_pkg::*;

  initial begin
    if (DIV < 2) $error("bmc_sw_timer: DIV must be at least 2");
  end

  typedef struct packed {
    logic [7:0] count;
    logic       start;
  } bmc_tmr_t;

  bmc_tmr_t cur;
  bmc_tmr_t next_cur;

  always_comb begin
    next_cur = cur;
    next_cur.start = 1'b0;
    if (!run) begin
      next_cur.count = 8'h00;
    end else if (cur.count == 8'(DIV) || cur.count == 8'h00) begin
      next_cur.count = 8'h01;
      next_cur.start = 1'b1;
    end else begin
      next_cur.count = cur.count + 8'h01;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign cycle_start = cur.start;

endmodule
`default_nettype wire

//--- bmc_sva.sv
/* checker for the bmc_top power stage outputs
   bound from the testbench; sees only top-level ports */
`default_nettype none
module bmc_sva (
  input wire logic                clock,              // system clock
  input wire logic                rst,                // sync reset
  input wire logic                enable_pin,         // converter enable
  input wire logic                voltage_select_pin, // setting select
  input wire bmc_pkg::bmc_sense_t sense,              // detector levels
  input wire bmc_pkg::bmc_drive_t drive               // stage controls
);
  timeunit 1ns;
  timeprecision 1ps;
  import bmc_pkg::*;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  sequence s_sw_off;
    !drive.main_on && !drive.sync_on;
  endsequence
  sequence s_pulse;
    drive.main_on ##1 !drive.main_on;
  endsequence
  a_hot_off: assert property (sense.over_temp |=> s_sw_off)
    else $error("switch on while hot");
  a_tsd_cause: assert property ($rose(drive.thermal_shutdown_state) |-> $past(sense.over_temp))
    else $error("shutdown without heat");
  a_uvlo_off: assert property (sense.uvlo |=> s_sw_off)
    else $error("switch on in lockout");
  a_main_pulse: assert property (drive.main_on |-> s_pulse)
    else $error("main switch pulse too long");
  a_en_low_off: assert property (!enable_pin [*2] |=> s_sw_off)
    else $error("switching with enable low");
  a_tsd_hold: assert property (drive.thermal_shutdown_state && sense.over_temp && enable_pin
    |=> drive.thermal_shutdown_state)
    else $error("left shutdown while hot");
  a_output_discharge_en_rst: assert property ($fell(rst) |-> !drive.discharge)
    else $error("discharge on after reset");
  a_reset_code: assert property ($fell(rst) ##0 voltage_select_pin [*3]
    |-> drive.vout_code == RST_CODE1)
    else $error("wrong code after reset");
endmodule
`default_nettype wire

//--- bmc_plant.sv
/* detector and power stage model for bmc_top
   assumes testbench commands change just after a rising edge */
`default_nettype none
module bmc_plant (
  input  wire logic                clock,   // system clock
  input  wire logic                rst,     // sync reset
  input  wire logic [1:0]          temp,    // 0 cool, 1 warm, 2 hot
  input  wire logic                low_vin, // supply under lockout
  input  wire logic                load,    // heavy load demand
  input  wire bmc_pkg::bmc_drive_t drive,   // switch controls
  output bmc_pkg::bmc_sense_t      sense,   // detector levels
  output logic                     overlap  // both switches seen on
);
  timeunit 1ns;
  timeprecision 1ps;
  import bmc_pkg::*;
  // comparators: hot above upper trip, recovered only below lower trip
  assign sense = {temp == 2'h2, temp == 2'h0, low_vin, load};
  always @(posedge clock) begin
    if (rst) overlap <= 1'h0;
    else if (drive.main_on && drive.sync_on) overlap <= 1'h1;
  end
endmodule
`default_nettype wire

//--- test_buck_output_mode_control.sv
/* testbench for bmc_top: apb tasks, read queue, detector model
   assumes bmc_pkg, bmc_top, bmc_plant and bmc_sva compiled first */
`default_nettype none
module test_buck_output_mode_control;
  timeunit 1ns;
  timeprecision 1ps;
  import bmc_pkg::*;
  logic        clock = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, irq, ovl;
  logic        enable_pin = 1'h0, voltage_select_pin = 1'h1, low_vin = 1'h0, load = 1'h0;
  logic [1:0]  temp = 2'h0;
  logic [6:0]  c0, c1;
  bmc_sense_t  sense;
  bmc_drive_t  drive;
  logic [63:0] q[$];
  int          num_errors = 0, checks_done = 0, n;
  always #4 clock = ~clock;
  bmc_top u_bmc_top (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .enable_pin(enable_pin), .voltage_select_pin(voltage_select_pin),
    .sense(sense), .drive(drive), .irq(irq));
  bmc_plant u_bmc_plant (.clock(clock), .rst(rst), .temp(temp), .low_vin(low_vin),
    .load(load), .drive(drive), .sense(sense), .overlap(ovl));
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    int k;
    k = 0;
    @(posedge clock);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'h1;
    do @(posedge clock); while (pready !== 1'h1 && k++ < 50);
    if (k >= 50) num_errors++;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic rd(logic [11:0] a, logic [31:0] e, logic [31:0] m = 32'hffffffff);
    q.push_back({m, e});
    apb(1'h0, a, 32'h0);
  endtask
  // read data and error are taken at the edge where pready is sampled high
  always @(posedge clock) begin
    if (psel && penable && pready) begin
      chk("pslverr", {31'h0, paddr > OFS_MASK}, {31'h0, pslverr});
      if (!pwrite) begin
        chk("prdata", q[0][31:0], prdata & q[0][63:32]);
        void'(q.pop_front());
      end
    end
  end
  task automatic final_report();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clock);
    num_errors++;
    final_report();
  end
  initial begin
    void'($urandom(32'h58e6));
    repeat (6) @(posedge clock);
    rst <= 1'h0;
    rd(OFS_SET0, RST_CODE0);
    rd(OFS_SET1, RST_CODE1);
    rd(OFS_CMD, 32'h4);
    rd(OFS_GOOD, 32'h0);
    rd(12'h020, 32'h0);
    enable_pin <= 1'h1;
    repeat (3) @(negedge clock);
    rd(OFS_STAT, 32'h1, 32'h3);
    $display("test reset and power-up done");
    c0 = 7'h7f;
    c1 = 7'($urandom);
    apb(1'h1, OFS_SET0, {25'h0, c0});
    apb(1'h1, OFS_SET1, {25'h0, c1});
    for (int i = 0; i < 4; i++) begin
      apb(1'h1, OFS_CMD, {29'h0, i[1], 2'h0});
      voltage_select_pin <= i[0];
      repeat (3) @(negedge clock);
      chk("vout_code", (i[1] && !i[0]) ? c0 : c1, drive.vout_code);
    end
    $display("test select done");
    for (int i = 0; i < 4; i++) begin
      apb(1'h1, OFS_CMD, {29'h1, i[1], !i[1]});
      load <= i[0];
      repeat (3) @(negedge clock);
      chk("pwm_mode", i[1] | i[0], drive.pwm_mode);
    end
    n = 0;
    while (drive.main_on !== 1'h1 && n++ < 200) @(negedge clock);
    n = 1;
    do @(negedge clock); while (drive.main_on !== 1'h1 && ++n < 200);
    chk("period", SW_DIV, n);
    $display("test mode done");
    apb(1'h1, OFS_MASK, 32'h2);
    low_vin <= 1'h1;
    repeat (4) @(negedge clock);
    chk("switches", 2'h0, {drive.main_on, drive.sync_on});
    chk("irq", 1'h1, irq);
    rd(OFS_IRQ, 32'h2, 32'h2);
    apb(1'h1, OFS_MASK, 32'h0);
    @(negedge clock);
    chk("irq", 1'h0, irq);
    apb(1'h1, OFS_IRQ, 32'h2);
    low_vin <= 1'h0;
    apb(1'h1, OFS_MASK, 32'h2);
    @(negedge clock);
    chk("irq", 1'h0, irq);
    $display("test lockout done");
    @(posedge clock);
    temp <= 2'h2;
    repeat (4) @(negedge clock);
    chk("tsd", 1'h1, drive.thermal_shutdown_state);
    chk("switches", 2'h0, {drive.main_on, drive.sync_on});
    @(posedge clock);
    temp <= 2'h0;
    repeat (10) @(negedge clock);
    rd(OFS_STAT, 32'h2, 32'h3);
    enable_pin <= 1'h0;
    repeat (2) @(posedge clock);
    enable_pin <= 1'h1;
    repeat (3) @(negedge clock);
    rd(OFS_STAT, 32'h1, 32'h3);
    apb(1'h1, OFS_LIM, 32'h1);
    apb(1'h1, OFS_SET0, 32'h15);
    temp <= 2'h2;
    repeat (4) @(posedge clock);
    temp <= 2'h1;
    repeat (6) @(negedge clock);
    rd(OFS_STAT, 32'h2, 32'h3);
    temp <= 2'h0;
    repeat (4) @(negedge clock);
    rd(OFS_STAT, 32'h1, 32'h3);
    rd(OFS_SET0, 32'h15);
    rd(OFS_IRQ, 32'h5, 32'h7);
    $display("test thermal done");
    apb(1'h1, OFS_GOOD, 32'h1);
    @(negedge clock);
    chk("discharge", 1'h1, drive.discharge);
    chk("overlap", 1'h0, ovl);
    $display("test discharge done");
    final_report();
  end
endmodule
bind bmc_top bmc_sva u_bmc_sva (.clock(clock), .rst(rst), .enable_pin(enable_pin),
  .voltage_select_pin(voltage_select_pin), .sense(sense), .drive(drive));
`default_nettype wire
